// File: bench/tb_top.sv
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("wrong value at %0t: got %h, expected %h", $time, a, e); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tccl_pkg::*;

  logic        i_clk, i_reset_n, aw_v, w_v, b_r, ar_v, r_r, pin, trip, run, pwr;
  logic        aw_r, w_r, b_v, ar_r, r_v, rv, tc, sr, lo, dv;
  logic [1:0]  rr, br, wb, rb;
  logic [15:0] vs, cs, mo, tg;
  logic [3:0]  ws;
  logic [11:0] aw_a, ar_a;
  logic [31:0] w_d, rd, r_d;
  logic [15:0] f, dflt, last, rs, v;
  int          fail_count, compares, m[10], a, b, k, op, ch, cl, sh, sl;
  int          ix[10] = '{10'h0c7, 10'h0c8, 10'h0c9, 10'h0cd, 10'h0cf,
                          10'h0d0, 10'h0ee, 10'h0ef, 10'h0f0, 10'h0f1};
  int          hi[10] = '{2000, 2000, 100, 2, 1, 1, 2000, 15, 15, 2};
  int          rst[10] = '{1000, 1000, 0, 0, 0, 0, 1000, 0, 0, 0};

  tccl_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_awaddr(aw_a), .i_awvalid(aw_v),
    .o_awready(aw_r), .i_wdata(w_d), .i_wstrb(ws), .i_wvalid(w_v), .o_wready(w_r),
    .o_bresp(br), .o_bvalid(b_v), .i_bready(b_r), .i_araddr(ar_a), .i_arvalid(ar_v),
    .o_arready(ar_r), .o_rdata(r_d), .o_rresp(rr), .o_rvalid(r_v), .i_rready(r_r),
    .i_funcs(f), .i_trip_clear_pin(pin), .i_trip_active(trip), .i_running(run),
    .i_power_up(pwr), .i_default_speed_setpoint(dflt), .i_last_updown_freq(last),
    .o_voltage_span_cal(vs), .o_current_span_cal(cs), .o_meter_offset_tune(mo),
    .o_thermistor_gain_tune(tg), .o_diag_view_enable(dv), .o_restore_setpoint(rs),
    .o_restore_valid(rv), .o_trip_cancel(tc), .o_stop_request(sr), .o_logic_out(lo));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Upper data bytes and strobes are random, so ignoring them is exercised too.
  task automatic wr(input int ad, input logic [15:0] d);
    int n = 0;
    aw_a <= 12'(ad * 4);
    w_d <= {16'($urandom), d};
    ws <= {2'($urandom), 2'b11};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!(b_v === 1'b1) && n < 50);
    wb = br;
    b_r <= 1'b0;
    if (n >= 50) fail_count++;
    if (n >= 50) finish_test();
    @(posedge i_clk);
  endtask

  task automatic rd_reg(input int ad);
    int n = 0;
    ar_a <= 12'(ad * 4);
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (ar_r) ar_v <= 1'b0;
    end while (!(r_v === 1'b1) && n < 50);
    rd = r_d;
    rb = rr;
    r_r <= 1'b0;
    if (n >= 50) fail_count++;
    if (n >= 50) finish_test();
    @(posedge i_clk);
  endtask

  initial begin
    {aw_v, w_v, b_r, ar_v, r_r, pin, trip, run, pwr, i_reset_n} = '0;
    {aw_a, ar_a, w_d, ws, f, dflt, last} = '0;
    void'($urandom(32'h2548_d6ba));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    for (k = 0; k < 10; k++) begin
      m[k] = rst[k];
      rd_reg(ix[k]);
      `CHK(rd, m[k])
    end
    // First pass is one above each limit, second the limit itself, then random.
    for (int j = 0; j < 50; j++) begin
      k = j % 10;
      v = (j < 10) ? 16'(hi[k] + 1) : (j < 20) ? 16'(hi[k]) : 16'($urandom_range(hi[k] + 1));
      wr(ix[k], v);
      if (v <= hi[k] && v >= (k == 6)) m[k] = v;
      rd_reg(ix[k]);
      `CHK(rd, m[k])
      `CHK({vs, cs, mo, tg, dv}, {16'(m[0]), 16'(m[1]), 16'(m[2]), 16'(m[6]), m[5] == 1})
    end
    $display("test register ranges done");
    wr(10'h0c0, 16'h1234);
    rd_reg(10'h0c0);
    `CHK(rd, 32'h0000_0000)
    `CHK(rb, RESP_OKAY)
    `CHK(wb, RESP_OKAY)
    $display("test reserved location done");
    for (int j = 0; j < 24; j++) begin
      a = $urandom_range(15);
      b = (j == 2) ? a : $urandom_range(15);
      op = j % 3;
      wr(ix[7], 16'(a));
      wr(ix[8], 16'(b));
      wr(ix[9], 16'(op));
      f <= 16'($urandom);
      repeat (2) @(posedge i_clk);
      `CHK(lo, op == 0 ? f[a] & f[b] : op == 1 ? f[a] | f[b] : f[a] ^ f[b])
    end
    $display("test combiner done");
    for (int r = 0; r < 2; r++) begin
      wr(ix[4], 16'(r));
      dflt <= 16'($urandom);
      last <= 16'($urandom);
      pwr <= 1'b1;
      @(posedge i_clk);
      pwr <= 1'b0;
      @(posedge i_clk);
      `CHK(rv, 1'b1)
      `CHK(rs, r ? last : dflt)
    end
    $display("test setpoint restore done");
    trip <= 1'b1;
    for (int j = 0; j < 6; j++) begin
      op = j / 2;
      wr(ix[3], 16'(op));
      run <= j[0];
      {ch, cl, sh, sl} = '0;
      for (int c = 0; c < 20; c++) begin
        pin <= (c < 10);
        @(posedge i_clk);
        ch += (c < 10 && tc !== 1'b0);
        sh += (c < 10 && sr !== 1'b0);
        cl += (c >= 10 && tc !== 1'b0);
        sl += (c >= 10 && sr !== 1'b0);
      end
      `CHK(ch, int'(op != 1 && !(op == 2 && j[0])))
      `CHK(cl, int'(op == 1))
      `CHK(sh, int'(op == 0 && j[0]))
      `CHK(sl, int'(op == 1 && j[0]))
    end
    $display("test trip clear done");
    finish_test();
  end
endmodule

// File: logic/tccl_combiner.sv
module tccl_combiner
  import tccl_pkg::*;
#(
  parameter int unsigned NUM_FUNCS = 16,
  parameter int unsigned SEL_W     = 4
)
(
  input  wire logic                 i_clk,     // System clock.
  input  wire logic                 i_reset_n, // Synchronous reset, active low.
  input  wire logic [NUM_FUNCS-1:0] i_funcs,   // Internal output functions.
  input  wire logic [SEL_W-1:0]     i_sel_a,   // Operand A select.
  input  wire logic [SEL_W-1:0]     i_sel_b,   // Operand B select.
  input  wire logic [15:0]          i_op,      // Operation code.
  output logic                      o_logic    // Combined output, registered.
);

  logic opa;
  logic opb;

  assign opa = i_funcs[i_sel_a];
  assign opb = i_funcs[i_sel_b];

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_logic <= 1'b0;
    end else begin
      unique case (i_op)
        OP_AND:  o_logic <= opa & opb;
        OP_OR:   o_logic <= opa | opb;
        OP_XOR:  o_logic <= opa ^ opb;
        default: o_logic <= 1'b0;
      endcase
    end
  end

  a_comb_result : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ##1 o_logic == (($past(i_op) == OP_AND) ? ($past(opa) & $past(opb)) :
                    ($past(i_op) == OP_OR)  ? ($past(opa) | $past(opb)) :
                    ($past(i_op) == OP_XOR) ? ($past(opa) ^ $past(opb)) : 1'b0))
    else $error("combined output does not match operands");

  a_operand_pick : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (i_sel_a == i_sel_b && i_op == OP_XOR) |=> !o_logic)
    else $error("same source on both operands must XOR to zero");

endmodule

// File: logic/tccl_edge_sync.sv
module tccl_edge_sync
  import tccl_pkg::*;
(
  input  wire logic i_clk,     // System clock.
  input  wire logic i_reset_n, // Synchronous reset, active low.
  input  wire logic i_pin,     // Asynchronous pin level.
  output logic      o_rise,    // One-cycle pulse on a low-to-high edge.
  output logic      o_fall     // One-cycle pulse on a high-to-low edge.
);

  logic       meta;
  logic       sync;
  logic       last;
  logic [1:0] warm;

  // ----------------------------------------------------------------
  // Synchroniser and edge detector
  // ----------------------------------------------------------------
  // Edges are held off until the pipe has seen real samples, so a pin
  // that is already high at reset release makes no false rise.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      warm <= 2'b00;
    end else begin
      meta <= i_pin;
      sync <= meta;
      last <= sync;
      if (warm != 2'b11) begin
        warm <= warm + 2'b01;
      end
    end
  end

  assign o_rise = (warm == 2'b11) && sync && !last;
  assign o_fall = (warm == 2'b11) && !sync && last;

  a_edge_single : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_rise || o_fall) |=> !(o_rise || o_fall))
    else $error("edge event lasted more than one cycle");

endmodule

// File: logic/tccl_pkg.sv
// Function
// - Hold voltage span scale, 0 to 2000.
// - Hold current span scale, 0 to 2000.
// - Hold meter offset tuning, 0 to 100.
// - Restore setpoint on power-up by retain code.
// - Code 00: cancel on rise, stop if running.
// - Code 01: cancel on fall, stop if running.
// - Code 02: cancel on rise, ignored while running.
// - Operand A picked by source-A select.
// - Operand B picked by source-B select.
// - Output is A AND, OR, XOR B.
package tccl_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W            = 10;
  localparam logic [9:0]  IDX_VOLT_SPAN    = 10'h0c7;
  localparam logic [9:0]  IDX_CURR_SPAN    = 10'h0c8;
  localparam logic [9:0]  IDX_METER_OFS    = 10'h0c9;
  localparam logic [9:0]  IDX_TRIP_POLICY  = 10'h0cd;
  localparam logic [9:0]  IDX_RETAIN_SEL   = 10'h0cf;
  localparam logic [9:0]  IDX_DIAG_VIEW    = 10'h0d0;
  localparam logic [9:0]  IDX_THERM_GAIN   = 10'h0ee;
  localparam logic [9:0]  IDX_SRC_A        = 10'h0ef;
  localparam logic [9:0]  IDX_SRC_B        = 10'h0f0;
  localparam logic [9:0]  IDX_COMB_OP      = 10'h0f1;

  // ----------------------------------------------------------------
  // Field limits and reset values
  // ----------------------------------------------------------------
  localparam int unsigned REG_W            = 16;
  localparam logic [15:0] SPAN_MAX         = 16'd2000;
  localparam logic [15:0] METER_MAX        = 16'd100;
  localparam logic [15:0] THERM_MIN        = 16'd1;
  localparam logic [15:0] THERM_MAX        = 16'd2000;
  localparam logic [15:0] RST_SPAN         = 16'd1000;
  localparam logic [15:0] RST_METER        = 16'h0000;
  localparam logic [15:0] RST_THERM        = 16'd1000;
  localparam logic [15:0] RST_CODE         = 16'h0000;

  // ----------------------------------------------------------------
  // Option codes
  // ----------------------------------------------------------------
  localparam logic [15:0] RETAIN_DEFAULT   = 16'h0000;
  localparam logic [15:0] RETAIN_KEEP      = 16'h0001;
  localparam logic [15:0] POL_ON_STOP      = 16'h0000;
  localparam logic [15:0] POL_OFF_STOP     = 16'h0001;
  localparam logic [15:0] POL_ON_IDLE      = 16'h0002;
  localparam logic [15:0] OP_AND           = 16'h0000;
  localparam logic [15:0] OP_OR            = 16'h0001;
  localparam logic [15:0] OP_XOR           = 16'h0002;
  localparam logic [15:0] DIAG_ON          = 16'h0001;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY        = 2'b00;

endpackage

// File: logic/tccl_top.sv
module tccl_top
  import tccl_pkg::*;
#(
  parameter int unsigned NUM_FUNCS = 16,
  parameter int unsigned ADDR_W    = 12
)
(
  input  wire logic                 i_clk,           // System clock, 200 MHz.
  input  wire logic                 i_reset_n,       // Synchronous reset, active low.
  input  wire logic [ADDR_W-1:0]    i_awaddr,        // Write address.
  input  wire logic                 i_awvalid,       // Write address valid.
  output logic                      o_awready,       // Write address ready.
  input  wire logic [31:0]          i_wdata,         // Write data.
  input  wire logic [3:0]           i_wstrb,         // Write byte strobes.
  input  wire logic                 i_wvalid,        // Write data valid.
  output logic                      o_wready,        // Write data ready.
  output logic [1:0]                o_bresp,         // Write response.
  output logic                      o_bvalid,        // Write response valid.
  input  wire logic                 i_bready,        // Write response ready.
  input  wire logic [ADDR_W-1:0]    i_araddr,        // Read address.
  input  wire logic                 i_arvalid,       // Read address valid.
  output logic                      o_arready,       // Read address ready.
  output logic [31:0]               o_rdata,         // Read data.
  output logic [1:0]                o_rresp,         // Read response.
  output logic                      o_rvalid,        // Read data valid.
  input  wire logic                 i_rready,        // Read data ready.
  input  wire logic [NUM_FUNCS-1:0] i_funcs,         // Internal output functions.
  input  wire logic                 i_trip_clear_pin,// Trip-clear pin, asynchronous.
  input  wire logic                 i_trip_active,   // Drive is in trip state.
  input  wire logic                 i_running,       // Drive is in run mode.
  input  wire logic                 i_power_up,      // Power-cycle restore pulse.
  input  wire logic [15:0]          i_default_speed_setpoint, // Default setpoint.
  input  wire logic [15:0]          i_last_updown_freq,       // Last stepped frequency.
  output logic [15:0]               o_voltage_span_cal,       // Voltage span, 0.1 %.
  output logic [15:0]               o_current_span_cal,       // Current span, 0.1 %.
  output logic [15:0]               o_meter_offset_tune,      // Meter offset, 0.1.
  output logic [15:0]               o_thermistor_gain_tune,   // Thermistor gain.
  output logic                      o_diag_view_enable,       // Diagnostic view on.
  output logic [15:0]               o_restore_setpoint,       // Restored setpoint.
  output logic                      o_restore_valid,          // Restore pulse.
  output logic                      o_trip_cancel,            // Trip cancel pulse.
  output logic                      o_stop_request,           // Stop pulse.
  output logic                      o_logic_out               // Combiner output.
);

  localparam int unsigned SEL_W = (NUM_FUNCS > 1) ? $clog2(NUM_FUNCS) : 1;

  if (NUM_FUNCS < 2 || NUM_FUNCS > 256) begin : g_bad_funcs
    $error("NUM_FUNCS must be 2 to 256");
  end
  if (ADDR_W < IDX_W + 2) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [9:0] idx);
    unique case (idx)
      IDX_VOLT_SPAN, IDX_CURR_SPAN, IDX_METER_OFS, IDX_TRIP_POLICY,
      IDX_RETAIN_SEL, IDX_DIAG_VIEW, IDX_THERM_GAIN, IDX_SRC_A,
      IDX_SRC_B, IDX_COMB_OP: is_mapped = 1'b1;
      default:                is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    merge = old;
    if (strb[0]) begin
      merge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge[15:8] = data[15:8];
    end
  endfunction

  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] trip_clear_policy;
  logic [15:0] updown_retain_select;
  logic [15:0] diag_view_enable;
  logic [15:0] combiner_source_a;
  logic [15:0] combiner_source_b;
  logic [15:0] combiner_op;

  logic        aw_full;
  logic        w_full;
  logic [9:0]  aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;
  logic [9:0]  ar_idx;
  logic [15:0] rd_word;
  logic        clr_rise;
  logic        clr_fall;
  logic        clr_evt;
  logic [15:0] funcs_max;

  assign funcs_max = 16'(NUM_FUNCS - 1);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are held separately, so the master may offer them
  // in either order; the write is done once both are here and the
  // previous response has been taken.
  assign o_awready = !aw_full;
  assign o_wready  = !w_full;
  assign wr_fire   = aw_full && w_full && !o_bvalid;
  assign o_bresp   = RESP_OKAY;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_full <= 1'b0;
      aw_idx  <= 10'h000;
    end else if (i_awvalid && o_awready) begin
      aw_full <= 1'b1;
      aw_idx  <= i_awaddr[IDX_W+1:2];
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_full <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_bvalid <= 1'b0;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // A value outside its legal range is dropped and the old value kept,
  // so the drive logic never sees a setting it cannot serve.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_voltage_span_cal     <= RST_SPAN;
      o_current_span_cal     <= RST_SPAN;
      o_meter_offset_tune    <= RST_METER;
      o_thermistor_gain_tune <= RST_THERM;
      trip_clear_policy      <= RST_CODE;
      updown_retain_select   <= RST_CODE;
      diag_view_enable       <= RST_CODE;
      combiner_source_a      <= RST_CODE;
      combiner_source_b      <= RST_CODE;
      combiner_op            <= RST_CODE;
    end else if (wr_fire) begin
      unique case (aw_idx)
        IDX_VOLT_SPAN: begin
          if (in_range(merge(o_voltage_span_cal, w_data, w_strb), 16'd0, SPAN_MAX)) begin
            o_voltage_span_cal <= merge(o_voltage_span_cal, w_data, w_strb);
          end
        end
        IDX_CURR_SPAN: begin
          if (in_range(merge(o_current_span_cal, w_data, w_strb), 16'd0, SPAN_MAX)) begin
            o_current_span_cal <= merge(o_current_span_cal, w_data, w_strb);
          end
        end
        IDX_METER_OFS: begin
          if (in_range(merge(o_meter_offset_tune, w_data, w_strb), 16'd0, METER_MAX)) begin
            o_meter_offset_tune <= merge(o_meter_offset_tune, w_data, w_strb);
          end
        end
        IDX_THERM_GAIN: begin
          if (in_range(merge(o_thermistor_gain_tune, w_data, w_strb), THERM_MIN,
                       THERM_MAX)) begin
            o_thermistor_gain_tune <= merge(o_thermistor_gain_tune, w_data, w_strb);
          end
        end
        IDX_TRIP_POLICY: begin
          if (in_range(merge(trip_clear_policy, w_data, w_strb), 16'd0, POL_ON_IDLE)) begin
            trip_clear_policy <= merge(trip_clear_policy, w_data, w_strb);
          end
        end
        IDX_RETAIN_SEL: begin
          if (in_range(merge(updown_retain_select, w_data, w_strb), 16'd0,
                       RETAIN_KEEP)) begin
            updown_retain_select <= merge(updown_retain_select, w_data, w_strb);
          end
        end
        IDX_DIAG_VIEW: begin
          if (in_range(merge(diag_view_enable, w_data, w_strb), 16'd0, DIAG_ON)) begin
            diag_view_enable <= merge(diag_view_enable, w_data, w_strb);
          end
        end
        IDX_SRC_A: begin
          if (in_range(merge(combiner_source_a, w_data, w_strb), 16'd0, funcs_max)) begin
            combiner_source_a <= merge(combiner_source_a, w_data, w_strb);
          end
        end
        IDX_SRC_B: begin
          if (in_range(merge(combiner_source_b, w_data, w_strb), 16'd0, funcs_max)) begin
            combiner_source_b <= merge(combiner_source_b, w_data, w_strb);
          end
        end
        IDX_COMB_OP: begin
          if (in_range(merge(combiner_op, w_data, w_strb), 16'd0, OP_XOR)) begin
            combiner_op <= merge(combiner_op, w_data, w_strb);
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign o_diag_view_enable = (diag_view_enable == DIAG_ON);

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign o_arready = !o_rvalid;
  assign rd_fire   = i_arvalid && o_arready;
  assign ar_idx    = i_araddr[IDX_W+1:2];
  assign o_rresp   = RESP_OKAY;

  always_comb begin
    rd_word = 16'h0000;
    if (is_mapped(ar_idx)) begin
      unique case (ar_idx)
        IDX_VOLT_SPAN:   rd_word = o_voltage_span_cal;
        IDX_CURR_SPAN:   rd_word = o_current_span_cal;
        IDX_METER_OFS:   rd_word = o_meter_offset_tune;
        IDX_THERM_GAIN:  rd_word = o_thermistor_gain_tune;
        IDX_TRIP_POLICY: rd_word = trip_clear_policy;
        IDX_RETAIN_SEL:  rd_word = updown_retain_select;
        IDX_DIAG_VIEW:   rd_word = diag_view_enable;
        IDX_SRC_A:       rd_word = combiner_source_a;
        IDX_SRC_B:       rd_word = combiner_source_b;
        IDX_COMB_OP:     rd_word = combiner_op;
        default:         rd_word = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0000_0000;
    end else if (rd_fire) begin
      o_rvalid <= 1'b1;
      o_rdata  <= {16'h0000, rd_word};
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Setpoint restore after a power cycle
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_restore_valid    <= 1'b0;
      o_restore_setpoint <= 16'h0000;
    end else begin
      o_restore_valid <= i_power_up;
      if (i_power_up) begin
        o_restore_setpoint <= (updown_retain_select == RETAIN_KEEP) ?
                              i_last_updown_freq : i_default_speed_setpoint;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trip clear
  // ----------------------------------------------------------------
  tccl_edge_sync u_clr_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_trip_clear_pin),
    .o_rise    (clr_rise),
    .o_fall    (clr_fall)
  );

  assign clr_evt = (trip_clear_policy == POL_OFF_STOP) ? clr_fall : clr_rise;

  // Under the idle-only policy a press during run does nothing at all,
  // not even a cancel, so a running drive is never disturbed.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_trip_cancel  <= 1'b0;
      o_stop_request <= 1'b0;
    end else begin
      o_trip_cancel  <= 1'b0;
      o_stop_request <= 1'b0;
      if (clr_evt) begin
        if (trip_clear_policy == POL_ON_IDLE) begin
          o_trip_cancel <= i_trip_active && !i_running;
        end else begin
          o_trip_cancel  <= i_trip_active;
          o_stop_request <= i_running;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Logic output combiner
  // ----------------------------------------------------------------
  tccl_combiner #(
    .NUM_FUNCS (NUM_FUNCS),
    .SEL_W     (SEL_W)
  ) u_comb (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_funcs   (i_funcs),
    .i_sel_a   (combiner_source_a[SEL_W-1:0]),
    .i_sel_b   (combiner_source_b[SEL_W-1:0]),
    .i_op      (combiner_op),
    .o_logic   (o_logic_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_volt_span_max : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_voltage_span_cal <= SPAN_MAX)
    else $error("voltage span above limit");

  a_curr_span_max : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_current_span_cal <= SPAN_MAX)
    else $error("current span above limit");

  a_meter_ofs_max : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_meter_offset_tune <= METER_MAX)
    else $error("meter offset above limit");

  a_restore_pick : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_power_up |=> o_restore_valid && (o_restore_setpoint ==
      (($past(updown_retain_select) == RETAIN_KEEP) ? $past(i_last_updown_freq) :
                                                       $past(i_default_speed_setpoint))))
    else $error("restored setpoint from wrong source");

  a_rise_stop : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (clr_rise && trip_clear_policy == POL_ON_STOP && i_running && i_trip_active)
    |=> o_stop_request && o_trip_cancel)
    else $error("rise under policy 00 did not cancel and stop");

  a_fall_cancel : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (clr_fall && trip_clear_policy == POL_OFF_STOP && i_trip_active)
    |=> o_trip_cancel ##1 !o_trip_cancel)
    else $error("fall under policy 01 did not cancel once");

  a_idle_only : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (trip_clear_policy == POL_ON_IDLE && i_running) |=> !o_stop_request && !o_trip_cancel)
    else $error("policy 02 acted while running");

  a_reserved_zero : assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (rd_fire && !is_mapped(ar_idx)) |=> o_rvalid && o_rdata == 32'h0000_0000)
    else $error("reserved location read non-zero");

endmodule
